// ### rtl/sbe_exec.sv
// execute stage for shift, add-with-carry, bit ops, skip and relative jumps
// assumes the decoder hands over the instruction, the addressed file value
// and the already incremented program counter on the same clock
`timescale 1ns/10ps
`default_nettype none

module sbe_exec (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // instruction from decoder
    input wire logic ISSUE_I,
    input wire sbe_pkg::sbe_instr_t INSTR_I,
    input wire logic [7:0] FILE_DATA_I,
    input wire logic [14:0] PC_NEXT_I,
    // core state
    output logic READY_O,
    output logic [7:0] ACC_O,
    output logic ACC_WE_O,
    output var sbe_pkg::sbe_flags_t FLAGS_O,
    // data memory write
    output logic FILE_WE_O,
    output logic [6:0] FILE_ADDR_O,
    output logic [7:0] FILE_DATA_O,
    // program counter control
    output logic PC_LOAD_O,
    output logic [14:0] PC_VALUE_O,
    output logic DISCARD_O
);

    // =========================================================
    // state registers
    sbe_pkg::sbe_regs_t st_r;
    sbe_pkg::sbe_regs_t st_nxt;
    logic take;
    logic [8:0] sum;
    logic [4:0] nib_sum;
    logic [7:0] result;

    assign take = ISSUE_I && st_r.ready;

    // next state of the execute stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.file_we = 1'h0;
        st_nxt.acc_we = 1'h0;
        st_nxt.pc_load = 1'h0;
        st_nxt.discard = 1'h0;
        st_nxt.ready = 1'h1;
        st_nxt.state = sbe_pkg::SBE_EXEC;
        sum = {1'h0, st_r.acc} + {1'h0, FILE_DATA_I} + {8'h00, st_r.flags.unsigned_overflow_bit};
        nib_sum = {1'h0, st_r.acc[3:0]} + {1'h0, FILE_DATA_I[3:0]}
            + {4'h0, st_r.flags.unsigned_overflow_bit};
        result = FILE_DATA_I;
        case (st_r.state)
            sbe_pkg::SBE_EXEC: begin
                if (take) begin
                    case (INSTR_I.op)
                        sbe_pkg::SBE_OP_ARITH_SHIFT_RIGHT_FILE: begin
                            result = {FILE_DATA_I[sbe_pkg::SIGN_BIT], FILE_DATA_I[7:1]};
                            st_nxt.flags.unsigned_overflow_bit = FILE_DATA_I[0];
                            st_nxt.flags.result_null_bit = (result == 8'h00);
                        end
                        sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE: begin
                            result = sum[7:0];
                            st_nxt.flags.unsigned_overflow_bit = sum[8];
                            st_nxt.flags.nibble_overflow_bit = nib_sum[4];
                            st_nxt.flags.result_null_bit = (result == 8'h00);
                        end
                        sbe_pkg::SBE_OP_BIT_CLEAR_FILE: begin
                            result[INSTR_I.bit_idx] = 1'h0;
                        end
                        sbe_pkg::SBE_OP_BIT_SET_FILE: begin
                            result[INSTR_I.bit_idx] = 1'h1;
                        end
                        sbe_pkg::SBE_OP_SKIP_IF_BIT_CLEAR: begin
                            if (!FILE_DATA_I[INSTR_I.bit_idx]) begin
                                st_nxt.discard = 1'h1;
                                st_nxt.ready = 1'h0;
                                st_nxt.state = sbe_pkg::SBE_IDLE_SLOT;
                            end
                        end
                        sbe_pkg::SBE_OP_JUMP_RELATIVE_LITERAL: begin
                            st_nxt.pc_value = PC_NEXT_I
                                + {{6{INSTR_I.offset[8]}}, INSTR_I.offset};
                            st_nxt.pc_load = 1'h1;
                            st_nxt.discard = 1'h1;
                            st_nxt.ready = 1'h0;
                            st_nxt.state = sbe_pkg::SBE_IDLE_SLOT;
                        end
                        sbe_pkg::SBE_OP_JUMP_RELATIVE_ACCUMULATOR: begin
                            st_nxt.pc_value = PC_NEXT_I + {7'h00, st_r.acc};
                            st_nxt.pc_load = 1'h1;
                            st_nxt.discard = 1'h1;
                            st_nxt.ready = 1'h0;
                            st_nxt.state = sbe_pkg::SBE_IDLE_SLOT;
                        end
                        default: begin
                            st_nxt.state = sbe_pkg::SBE_EXEC;
                        end
                    endcase
                    // route the result of shift and add by the destination bit
                    if (INSTR_I.op == sbe_pkg::SBE_OP_ARITH_SHIFT_RIGHT_FILE
                        || INSTR_I.op == sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE) begin
                        if (INSTR_I.dest == sbe_pkg::DEST_ACC) begin
                            st_nxt.acc = result;
                            st_nxt.acc_we = 1'h1;
                        end else begin
                            st_nxt.file_we = 1'h1;
                        end
                    end
                    // bit ops always write back to the file register
                    if (INSTR_I.op == sbe_pkg::SBE_OP_BIT_CLEAR_FILE
                        || INSTR_I.op == sbe_pkg::SBE_OP_BIT_SET_FILE) begin
                        st_nxt.file_we = 1'h1;
                    end
                    st_nxt.file_addr = INSTR_I.file_addr;
                    st_nxt.file_data = result;
                end
            end
            sbe_pkg::SBE_IDLE_SLOT: begin
                // the substituted idle cycle; issue is refused here
                st_nxt.state = sbe_pkg::SBE_EXEC;
            end
            default: begin
                st_nxt.state = sbe_pkg::SBE_EXEC;
            end
        endcase
    end

    // register the state
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            st_r <= '{state: sbe_pkg::SBE_EXEC, acc: sbe_pkg::ACC_RESET, flags: 3'h0,
                file_we: 1'h0, file_addr: sbe_pkg::ADDR_RESET, file_data: 8'h00,
                pc_load: 1'h0, pc_value: sbe_pkg::PC_RESET, discard: 1'h0,
                ready: 1'h1, acc_we: 1'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flip-flops
    assign READY_O = st_r.ready;
    assign ACC_O = st_r.acc;
    assign ACC_WE_O = st_r.acc_we;
    assign FLAGS_O = st_r.flags;
    assign FILE_WE_O = st_r.file_we;
    assign FILE_ADDR_O = st_r.file_addr;
    assign FILE_DATA_O = st_r.file_data;
    assign PC_LOAD_O = st_r.pc_load;
    assign PC_VALUE_O = st_r.pc_value;
    assign DISCARD_O = st_r.discard;

    // =========================================================
    // checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sbe_pkg::sbe_op_t p_op;
    logic p_take;
    assign p_op = INSTR_I.op;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            p_take <= 1'h0;
        end else begin
            p_take <= take;
        end
    end

    AST_SHIFT_RESULT: assert property (
        take && p_op == sbe_pkg::SBE_OP_ARITH_SHIFT_RIGHT_FILE
        |=> FLAGS_O.unsigned_overflow_bit == $past(FILE_DATA_I[0])
            && FILE_DATA_O == {$past(FILE_DATA_I[7]), $past(FILE_DATA_I[7:1])}
            && FLAGS_O.nibble_overflow_bit == $past(FLAGS_O.nibble_overflow_bit))
        else $error("shift result or carry wrong");
    AST_DEST_ROUTE: assert property (
        take && (p_op == sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE
            || p_op == sbe_pkg::SBE_OP_ARITH_SHIFT_RIGHT_FILE)
        |=> (FILE_WE_O == $past(INSTR_I.dest)) && (ACC_WE_O != $past(INSTR_I.dest)))
        else $error("destination select ignored");
    AST_ADD_SUM: assert property (
        take && p_op == sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE
        |=> {FLAGS_O.unsigned_overflow_bit, FILE_DATA_O} == {1'h0, $past(ACC_O)}
            + {1'h0, $past(FILE_DATA_I)} + {8'h00, $past(FLAGS_O.unsigned_overflow_bit)})
        else $error("add with carry sum wrong");
    AST_BIT_CLEAR: assert property (
        take && p_op == sbe_pkg::SBE_OP_BIT_CLEAR_FILE
        |=> FILE_WE_O && !FILE_DATA_O[$past(INSTR_I.bit_idx)] && $stable(FLAGS_O))
        else $error("bit clear wrong");
    AST_BIT_SET: assert property (
        take && p_op == sbe_pkg::SBE_OP_BIT_SET_FILE
        |=> FILE_WE_O && FILE_DATA_O[$past(INSTR_I.bit_idx)] && $stable(FLAGS_O))
        else $error("bit set wrong");
    AST_SKIP: assert property (
        take && p_op == sbe_pkg::SBE_OP_SKIP_IF_BIT_CLEAR
        |=> DISCARD_O == !$past(FILE_DATA_I[INSTR_I.bit_idx]) && READY_O == !DISCARD_O
            && $stable(FLAGS_O) ##1 (READY_O || $past(READY_O)))
        else $error("skip test wrong");
    AST_JUMP_LIT: assert property (
        take && p_op == sbe_pkg::SBE_OP_JUMP_RELATIVE_LITERAL
        |=> PC_LOAD_O && DISCARD_O && !READY_O && $stable(FLAGS_O) && PC_VALUE_O == $past(PC_NEXT_I)
            + {{6{$past(INSTR_I.offset[8])}}, $past(INSTR_I.offset)} ##1 READY_O)
        else $error("literal jump wrong");
    AST_JUMP_ACC: assert property (
        take && p_op == sbe_pkg::SBE_OP_JUMP_RELATIVE_ACCUMULATOR
        |=> PC_LOAD_O && DISCARD_O && !READY_O && $stable(FLAGS_O)
            && PC_VALUE_O == $past(PC_NEXT_I) + {7'h00, $past(ACC_O)} ##1 READY_O)
        else $error("accumulator jump wrong");
    AST_NULL_FLAG: assert property (
        p_take && ($past(p_op) == sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE
            || $past(p_op) == sbe_pkg::SBE_OP_ARITH_SHIFT_RIGHT_FILE)
        |-> FLAGS_O.result_null_bit == (FILE_DATA_O == 8'h00))
        else $error("null flag wrong");

    COV_SKIP_TAKEN: cover property (take && p_op == sbe_pkg::SBE_OP_SKIP_IF_BIT_CLEAR
        ##1 DISCARD_O);
    COV_BACK_JUMP: cover property (take && p_op == sbe_pkg::SBE_OP_JUMP_RELATIVE_LITERAL
        && INSTR_I.offset[8]);
    COV_ADD_CARRY: cover property (take && p_op == sbe_pkg::SBE_OP_ADD_WITH_CARRY_FILE
        ##1 FLAGS_O.unsigned_overflow_bit);

endmodule

`default_nettype wire

// ### rtl/sbe_pkg.sv
// package for the shift, bit-op and relative-branch execute block
// assumes one core instruction clock and a decoder in the same domain
`default_nettype none

package sbe_pkg;

    // =========================================================
    // widths and fixed figures
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 15;
    localparam int OFFS_W = 9;
    localparam int BIT_IDX_W = 3;
    localparam int MULTI_CYCLES = 2; // cycles of a branch or a taken skip
    localparam int NIBBLE_MSB = 3;
    localparam int SIGN_BIT = 7;

    // =========================================================
    // destination select values
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // =========================================================
    // values after reset
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

    // =========================================================
    // operations handled here
    typedef enum logic [2:0] {
        SBE_OP_ARITH_SHIFT_RIGHT_FILE,
        SBE_OP_ADD_WITH_CARRY_FILE,
        SBE_OP_BIT_CLEAR_FILE,
        SBE_OP_BIT_SET_FILE,
        SBE_OP_SKIP_IF_BIT_CLEAR,
        SBE_OP_JUMP_RELATIVE_LITERAL,
        SBE_OP_JUMP_RELATIVE_ACCUMULATOR
    } sbe_op_t;

    // decoded instruction with its operand fields
    typedef struct packed {
        sbe_op_t op;
        logic [ADDR_W-1:0] file_addr;
        logic dest;
        logic [BIT_IDX_W-1:0] bit_idx;
        logic [OFFS_W-1:0] offset;
    } sbe_instr_t;

    // status flags
    typedef struct packed {
        logic unsigned_overflow_bit;
        logic nibble_overflow_bit;
        logic result_null_bit;
    } sbe_flags_t;

    // execute states
    typedef enum logic {
        SBE_EXEC,
        SBE_IDLE_SLOT
    } sbe_state_t;

    // whole state of the execute block
    typedef struct packed {
        sbe_state_t state;
        logic [DATA_W-1:0] acc;
        sbe_flags_t flags;
        logic file_we;
        logic [ADDR_W-1:0] file_addr;
        logic [DATA_W-1:0] file_data;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic discard;
        logic ready;
        logic acc_we;
    } sbe_regs_t;

endpackage

`default_nettype wire

// ### sim/sbe_exec_tb.sv
// self-checking bench for the shift, bit-op and relative-jump execute block
// assumes the block answers one cycle after issue and ignores issue when not ready
`timescale 1ns/10ps
`default_nettype none

module sbe_exec_tb;
    // =========================================================
    // stimulus and observed signals
    logic SYS_CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic ISSUE_I = 1'b0;
    sbe_pkg::sbe_instr_t INSTR_I = '0;
    logic [7:0] FILE_DATA_I = 8'h00;
    logic [14:0] PC_NEXT_I = 15'h0000;
    logic READY_O;
    logic [7:0] ACC_O;
    logic ACC_WE_O;
    sbe_pkg::sbe_flags_t FLAGS_O;
    logic FILE_WE_O;
    logic [6:0] FILE_ADDR_O;
    logic [7:0] FILE_DATA_O;
    logic PC_LOAD_O;
    logic [14:0] PC_VALUE_O;
    logic DISCARD_O;
    int bad_count = 0;
    int checks_done = 0;
    integer seed = 32'hef918af2;
    integer r1;
    integer r2;
    logic [7:0] m_acc = 8'h00;
    sbe_pkg::sbe_flags_t m_fl = '0;

    sbe_exec DUT (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ISSUE_I(ISSUE_I), .INSTR_I(INSTR_I),
        .FILE_DATA_I(FILE_DATA_I), .PC_NEXT_I(PC_NEXT_I), .READY_O(READY_O), .ACC_O(ACC_O),
        .ACC_WE_O(ACC_WE_O), .FLAGS_O(FLAGS_O), .FILE_WE_O(FILE_WE_O),
        .FILE_ADDR_O(FILE_ADDR_O), .FILE_DATA_O(FILE_DATA_O), .PC_LOAD_O(PC_LOAD_O),
        .PC_VALUE_O(PC_VALUE_O), .DISCARD_O(DISCARD_O));

    // free-running core clock, 40 ns period
    always #20 SYS_CLK_I = ~SYS_CLK_I;

    // =========================================================
    // compare and report tasks
    task automatic chk_flag(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_val(input string nm, input logic [14:0] e, input logic [14:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // values that reset must leave on every output
    task automatic chk_reset();
        chk_val("reset", 15'h0000, {ACC_O, FLAGS_O, FILE_WE_O, ACC_WE_O, PC_LOAD_O, DISCARD_O});
        chk_val("reset_file", 15'h0000, {FILE_ADDR_O, FILE_DATA_O});
        chk_val("reset_target", 15'h0000, PC_VALUE_O);
        chk_flag("reset_ready", 1'b1, READY_O);
    endtask

    // issue held low: an offered instruction must leave no trace
    task automatic no_issue(input logic [2:0] op, input logic [7:0] f);
        ISSUE_I = 1'b0;
        INSTR_I.op = sbe_pkg::sbe_op_t'(op);
        FILE_DATA_I = f;
        @(posedge SYS_CLK_I);
        #1;
        chk_val("quiet_strobes", 15'h0001,
            {10'h000, FILE_WE_O, ACC_WE_O, PC_LOAD_O, DISCARD_O, READY_O});
        chk_val("quiet_state", {4'h0, m_fl, m_acc}, {4'h0, FLAGS_O, ACC_O});
    endtask

    // =========================================================
    // expected result: {nibble carry, carry, eight-bit result}
    function automatic logic [9:0] alu(input logic [2:0] op, input logic [7:0] f,
        input logic [7:0] a, input logic c, input logic [2:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, f} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, c};
        case (op)
            3'h0: alu = {1'b0, f[0], f[7], f[7:1]};
            3'h1: alu = {h[4], s};
            3'h2: alu = {2'b00, f & ~(8'h01 << b)};
            3'h3: alu = {2'b00, f | (8'h01 << b)};
            default: alu = {2'b00, f};
        endcase
    endfunction

    // issue one instruction, check cycle 1 and, for two-cycle ops, the idle slot
    task automatic run_op(input logic [2:0] op, input logic [6:0] ad, input logic d,
        input logic [2:0] b, input logic [8:0] o, input logic [7:0] f, input logic [14:0] nx);
        logic [9:0] x;
        logic fw;
        logic aw;
        logic ld;
        logic dsc;
        logic [14:0] tgt;
        sbe_pkg::sbe_flags_t fl;
        x = alu(op, f, m_acc, m_fl.unsigned_overflow_bit, b);
        fl = m_fl;
        fw = (op == 3'h2 || op == 3'h3);
        aw = 1'b0;
        ld = (op == 3'h5 || op == 3'h6);
        dsc = ld || (op == 3'h4 && !f[b]);
        tgt = (op == 3'h5) ? nx + {{6{o[8]}}, o} : nx + {7'h00, m_acc};
        if (op == 3'h0 || op == 3'h1) begin
            fl.unsigned_overflow_bit = x[8];
            fl.result_null_bit = (x[7:0] == 8'h00);
            fl.nibble_overflow_bit = (op == 3'h1) ? x[9] : m_fl.nibble_overflow_bit;
            fw = d;
            aw = !d;
        end
        ISSUE_I = 1'b1;
        INSTR_I = '{op: sbe_pkg::sbe_op_t'(op), file_addr: ad, dest: d, bit_idx: b, offset: o};
        FILE_DATA_I = f;
        PC_NEXT_I = nx;
        @(posedge SYS_CLK_I);
        #1;
        if (aw) begin
            m_acc = x[7:0];
        end
        m_fl = fl;
        chk_flag("acc_we", aw, ACC_WE_O);
        chk_val("acc", {7'h00, m_acc}, {7'h00, ACC_O});
        chk_val("flags", {12'h000, m_fl}, {12'h000, FLAGS_O});
        chk_flag("file_we", fw, FILE_WE_O);
        if (fw) begin
            chk_val("file_data", {7'h00, x[7:0]}, {7'h00, FILE_DATA_O});
            chk_val("file_addr", {8'h00, ad}, {8'h00, FILE_ADDR_O});
        end
        chk_flag("discard", dsc, DISCARD_O);
        chk_flag("load", ld, PC_LOAD_O);
        chk_flag("ready", !dsc, READY_O);
        if (ld) begin
            chk_val("target", tgt, PC_VALUE_O);
        end
        if (dsc) begin
            // issue stays high through the idle slot and must be ignored
            @(posedge SYS_CLK_I);
            #1;
            chk_val("slot", 15'h0001, {11'h000, FILE_WE_O, ACC_WE_O, PC_LOAD_O, READY_O});
            chk_val("slot_flags", {12'h000, m_fl}, {12'h000, FLAGS_O});
        end
    endtask

    // =========================================================
    // main sequence: reset, corner cases, then random traffic
    initial begin
        repeat (5) @(posedge SYS_CLK_I);
        #1;
        RST_I = 1'b0;
        chk_reset();
        run_op(3'h0, 7'h05, 1'b1, 3'h0, 9'h000, 8'h81, 15'h0001);
        run_op(3'h0, 7'h06, 1'b0, 3'h0, 9'h000, 8'h01, 15'h0002);
        run_op(3'h1, 7'h07, 1'b0, 3'h0, 9'h000, 8'hff, 15'h0003);
        run_op(3'h1, 7'h7f, 1'b1, 3'h0, 9'h000, 8'h0f, 15'h0004);
        for (int i = 0; i < 8; i++) begin
            run_op(3'h2, 7'h10, 1'b0, i[2:0], 9'h000, 8'hff, 15'h0005);
            run_op(3'h3, 7'h11, 1'b0, i[2:0], 9'h000, 8'h00, 15'h0006);
            run_op(3'h4, 7'h12, 1'b0, i[2:0], 9'h000, 8'h01 << i, 15'h0007);
            run_op(3'h4, 7'h12, 1'b0, i[2:0], 9'h000, ~(8'h01 << i), 15'h0008);
        end
        run_op(3'h5, 7'h00, 1'b0, 3'h0, 9'h100, 8'h00, 15'h0010);
        run_op(3'h5, 7'h00, 1'b0, 3'h0, 9'h0ff, 8'h00, 15'h7fff);
        run_op(3'h1, 7'h01, 1'b0, 3'h0, 9'h000, 8'hf0, 15'h0011);
        run_op(3'h6, 7'h00, 1'b0, 3'h0, 9'h000, 8'h00, 15'h7f80);
        run_op(3'h7, 7'h02, 1'b1, 3'h1, 9'h1ff, 8'h55, 15'h0012);
        // reset again in mid-run: the model and all outputs except READY_O restart from zero
        ISSUE_I = 1'b0;
        RST_I = 1'b1;
        repeat (2) @(posedge SYS_CLK_I);
        #1;
        RST_I = 1'b0;
        m_acc = 8'h00;
        m_fl = '0;
        chk_reset();
        for (int n = 0; n < 400; n++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            if (r2[23]) begin
                no_issue(r1[2:0], r2[7:0]);
            end
            run_op(r1[2:0], r1[9:3], r1[10], r1[13:11], r1[22:14], r2[7:0], r2[22:8]);
        end
        ISSUE_I = 1'b0;
        @(posedge SYS_CLK_I);
        complete_run();
    end
endmodule

`default_nettype wire
